//--- inc/parameter_load_defines.svh
// Constants of the parameter-load request parser: block layout, codes, register map.
// Assumes 16-bit command block words and a 32-bit APB register bus.
`ifndef PARAMETER_LOAD_DEFINES_SVH
`define PARAMETER_LOAD_DEFINES_SVH

// ==========================================================================
// Command block layout (zero-based word indices)
`define BLOCK_WORDS       44
`define W_HDR_LEN         6'h00
`define W_BLOCKING_FLAG   6'h01
`define W_STAT_AREA       6'h02
`define W_STAT_OFFSET     6'h03
`define W_IDLE_TIMEOUT    6'h04
`define W_MAX_COMM_TIME   6'h05
`define W_CMD_CODE        6'h06
`define W_DATA_SIZE       6'h07
`define W_DATA_AREA       6'h08
`define W_DATA_OFFSET     6'h09
`define W_START_NUMBER    6'h0a
`define W_PARAM_COUNT     6'h0b
`define W_VALUES          6'h0c

// ==========================================================================
// Codes and limits
`define CMD_PARAM_LOAD    16'he501
`define AREA_DISC_IN      16'h0046
`define AREA_DISC_OUT     16'h0048
`define AREA_REGISTER     16'h0008
`define AREA_ANALOG_IN    16'h000a
`define AREA_ANALOG_OUT   16'h000c
`define SPEC_BYTES        18'h00004
`define MAX_PARAMS        16'h0010
`define MAX_PARAM_NUMBER  16'h00ff
`define PARAM_NUMBER_END  17'h00100
`define BITS_PER_WORD_LOG 4

// ==========================================================================
// Status word values
`define STAT_PENDING      16'h0000
`define STAT_OK           16'h0001
`define STAT_ERR_CMD      16'h0002
`define STAT_ERR_AREA     16'h0003
`define STAT_ERR_COUNT    16'h0004
`define STAT_ERR_START    16'h0005
`define STAT_ERR_RANGE    16'h0006
`define STAT_ERR_SIZE     16'h0007

// ==========================================================================
// Register byte offsets
`define REG_CTRL          12'h000
`define REG_STATUS        12'h004
`define REG_STATUS_WORD   12'h008
`define REG_STATUS_END    12'h00c
`define REG_DATA_END      12'h010
`define REG_PARAM_INDEX   12'h014
`define REG_PARAM_VALUE   12'h018
`define REG_LOAD_COUNT    12'h01c
`define REG_BLOCK_PAGE    4'h1

`endif

//--- inc/parameter_load_pkg.sv
// Types shared by the parameter-load request parser.
// Assumes the constants header is on the include path.
`include "parameter_load_defines.svh"

package parameter_load_pkg;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_CHECK  = 2'b01,
    ST_LOAD   = 2'b11,
    ST_FINISH = 2'b10
  } parse_state_type;

  typedef struct packed {
    parse_state_type state;
    logic [4:0]      index;
    logic [7:0]      number;
    logic [4:0]      loaded;
    logic [15:0]     status_word;
    logic            busy;
    logic            done;
    logic            error;
    logic [7:0]      view_index;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic            wr_valid;
    logic [7:0]      wr_number;
    logic [31:0]     wr_value;
  } parser_state_type;

endpackage : parameter_load_pkg

//--- src/area_decode.sv
// Decodes a memory area code and works out the last address a span occupies.
// Assumes discrete areas are addressed in bits and word areas in 16-bit words.
`timescale 1ns/1ps
`include "parameter_load_defines.svh"

module area_decode
  import parameter_load_pkg::*;
#(
  parameter int UNIT_WIDTH = 6
)
(
  input  wire logic [15:0]           code,
  input  wire logic [15:0]           offset,
  input  wire logic [UNIT_WIDTH-1:0] units,
  output logic                       valid,
  output logic                       discrete,
  output logic [31:0]                span_end
);

  logic [31:0] scaled;

  always_comb
  begin
    discrete = (code == `AREA_DISC_IN) || (code == `AREA_DISC_OUT);
    valid    = discrete || (code == `AREA_REGISTER)
               || (code == `AREA_ANALOG_IN) || (code == `AREA_ANALOG_OUT);
    // A discrete area spends sixteen bits on every word of the span.
    scaled   = discrete ? (32'(units) << `BITS_PER_WORD_LOG) : 32'(units);
    // The offset is zero based, so the span ends one short of offset plus size.
    span_end = {16'h0000, offset} + scaled - 32'h0000_0001;
  end

endmodule : area_decode

//--- src/parameter_load_request_parser.sv
// APB-attached parser that interprets a parameter-load command block and loads parameters.
// Assumes one clock, an asynchronous active-high reset and a well-behaved APB master.
//
// Function
// - Word 3 selects the status area; register memory is code 8.
// - A discrete status area takes sixteen consecutive bits from the offset.
// - Status offset in word 4 is zero based.
// - Words 5 and 6 are written as zero and ignored.
// - Word 7 must hold command code e501 hex.
// - Word 8 equals four plus four times the count, 8 to 68 bytes.
// - At most sixteen parameters are accepted in one request.
// - Words 9 and 10 give area and offset of the parameter data.
// - Starting parameter number lies between zero and 255.
// - Each value is two 16-bit words following the two specifier words.
// - Only as many value pairs as the count are read.
// - Area codes: 70 and 72 discrete, 10 and 12 analog.
// - Parameter count lies between one and sixteen.
// - Start number plus count must keep the last parameter at or below 255.
// - A discrete data area takes 32 bits per parameter, 16 per specifier.
`timescale 1ns/1ps
`include "parameter_load_defines.svh"

module parameter_load_request_parser
  import parameter_load_pkg::*;
#(
  parameter int PARAM_DEPTH = 256
)
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             param_write_valid,
  output logic      [7:0]  param_write_number,
  output logic      [31:0] param_write_value,
  output logic             request_busy,
  output logic             request_done
);

  // ========================================================================
  // Storage
  parser_state_type q;
  parser_state_type next_q;
  logic [15:0]      block_mem [`BLOCK_WORDS];
  logic [31:0]      param_mem [PARAM_DEPTH];

  // ========================================================================
  // Decoded command block fields
  logic [15:0] cmd_word;
  logic [15:0] size_word;
  logic [15:0] start_word;
  logic [15:0] count_word;
  logic [15:0] stat_area;
  logic [15:0] stat_offset;
  logic [15:0] data_area;
  logic [15:0] data_offset;
  logic [15:0] pair_low;
  logic [15:0] pair_high;
  logic [31:0] pair_value;
  logic [5:0]  data_units;
  logic        stat_valid;
  logic        stat_discrete;
  logic [31:0] stat_end;
  logic        data_valid;
  logic        data_discrete;
  logic [31:0] data_end;
  logic [15:0] err_code;

  assign cmd_word    = block_mem[`W_CMD_CODE];
  assign size_word   = block_mem[`W_DATA_SIZE];
  assign start_word  = block_mem[`W_START_NUMBER];
  assign count_word  = block_mem[`W_PARAM_COUNT];
  assign stat_area   = block_mem[`W_STAT_AREA];
  assign stat_offset = block_mem[`W_STAT_OFFSET];
  assign data_area   = block_mem[`W_DATA_AREA];
  assign data_offset = block_mem[`W_DATA_OFFSET];
  // Low word of a value comes first, high word right after it.
  assign pair_low    = block_mem[`W_VALUES + {q.index, 1'b0}];
  assign pair_high   = block_mem[`W_VALUES + {q.index, 1'b1}];
  assign pair_value  = {pair_high, pair_low};
  // Two specifier words plus two words per value.
  assign data_units  = 6'h02 + {count_word[4:0], 1'b0};

  area_decode #(
    .UNIT_WIDTH (6)
  ) status_area_decode (
    .code     (stat_area),
    .offset   (stat_offset),
    .units    (6'h01),
    .valid    (stat_valid),
    .discrete (stat_discrete),
    .span_end (stat_end)
  );

  area_decode #(
    .UNIT_WIDTH (6)
  ) data_area_decode (
    .code     (data_area),
    .offset   (data_offset),
    .units    (data_units),
    .valid    (data_valid),
    .discrete (data_discrete),
    .span_end (data_end)
  );

  request_checker field_check (
    .cmd_code     (cmd_word),
    .data_size    (size_word),
    .start_number (start_word),
    .param_count  (count_word),
    .status_valid (stat_valid),
    .data_valid   (data_valid),
    .err_code     (err_code)
  );

  // ========================================================================
  // APB decode
  logic       access;
  logic       block_hit;
  logic [5:0] block_index;
  logic       wr_commit;
  logic       start_req;

  assign access      = psel && penable;
  assign block_index = paddr[7:2];
  assign block_hit   = (paddr[11:8] == `REG_BLOCK_PAGE) && (paddr[1:0] == 2'b00)
                       && (block_index < 6'(`BLOCK_WORDS));
  // A write lands only at the edge where pready is sampled high.
  assign wr_commit   = access && q.pready && pwrite && !q.pslverr;
  assign start_req   = wr_commit && (paddr == `REG_CTRL) && pwdata[0];

  // ========================================================================
  // Next-state logic
  always_comb
  begin
    next_q          = q;
    next_q.wr_valid = 1'b0;
    next_q.pready   = 1'b0;
    next_q.pslverr  = 1'b0;

    if (access && !q.pready)
    begin
      next_q.pready = 1'b1;
      next_q.prdata = 32'h0000_0000;
      if (block_hit)
      begin
        next_q.prdata  = {16'h0000, block_mem[block_index]};
        next_q.pslverr = pwrite && q.busy;
      end
      else
      begin
        case (paddr)
          `REG_CTRL:        next_q.pslverr = pwrite && q.busy;
          `REG_STATUS:      next_q.prdata = {29'h0, q.error, q.done, q.busy};
          `REG_STATUS_WORD: next_q.prdata = {16'h0000, q.status_word};
          `REG_STATUS_END:  next_q.prdata = stat_end;
          `REG_DATA_END:    next_q.prdata = data_end;
          `REG_PARAM_INDEX: next_q.prdata = {24'h0, q.view_index};
          `REG_PARAM_VALUE: next_q.prdata = param_mem[q.view_index];
          `REG_LOAD_COUNT:  next_q.prdata = {27'h0, q.loaded};
          default:          next_q.pslverr = 1'b1;
        endcase
        if (!pwrite && paddr == `REG_CTRL)
          next_q.prdata = 32'h0000_0000;
      end
    end

    if (wr_commit && paddr == `REG_PARAM_INDEX)
      next_q.view_index = pwdata[7:0];

    case (q.state)
      ST_IDLE:
      begin
        if (start_req)
        begin
          next_q.busy        = 1'b1;
          next_q.done        = 1'b0;
          next_q.error       = 1'b0;
          next_q.status_word = `STAT_PENDING;
          next_q.state       = ST_CHECK;
        end
      end
      ST_CHECK:
      begin
        if (err_code != `STAT_PENDING)
        begin
          next_q.status_word = err_code;
          next_q.error       = 1'b1;
          next_q.state       = ST_FINISH;
        end
        else
        begin
          next_q.index  = 5'h00;
          next_q.loaded = 5'h00;
          next_q.number = start_word[7:0];
          next_q.state  = ST_LOAD;
        end
      end
      ST_LOAD:
      begin
        next_q.wr_valid  = 1'b1;
        next_q.wr_number = q.number;
        next_q.wr_value  = pair_value;
        next_q.number    = q.number + 8'h01;
        next_q.index     = q.index + 5'h01;
        next_q.loaded    = q.loaded + 5'h01;
        // Stop after the last counted pair; later slots are never read.
        if ({11'h000, q.index} == count_word - 16'h0001)
        begin
          next_q.status_word = `STAT_OK;
          next_q.state       = ST_FINISH;
        end
      end
      ST_FINISH:
      begin
        next_q.busy  = 1'b0;
        next_q.done  = 1'b1;
        next_q.state = ST_IDLE;
      end
      default:
      begin
        next_q.state = ST_IDLE;
      end
    endcase
  end

  // ========================================================================
  // State registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      q       <= '0;
      q.state <= ST_IDLE;
    end
    else
    begin
      q <= next_q;
    end
  end

  // Memories hold no reset; software fills the block before starting.
  always_ff @(posedge clk_sys)
  begin
    if (wr_commit && block_hit)
      block_mem[block_index] <= pwdata[15:0];
    if (q.wr_valid)
      param_mem[q.wr_number] <= q.wr_value;
  end

  assign prdata             = q.prdata;
  assign pready             = q.pready;
  assign pslverr            = q.pslverr;
  assign param_write_valid  = q.wr_valid;
  assign param_write_number = q.wr_number;
  assign param_write_value  = q.wr_value;
  assign request_busy       = q.busy;
  assign request_done       = q.done;

  // ========================================================================
  // Assertions
  property p_cmd_reject;
    @(posedge clk_sys) disable iff (rst)
    (q.state == ST_CHECK) && (cmd_word != `CMD_PARAM_LOAD)
      |=> (q.status_word == `STAT_ERR_CMD) && q.error && (q.state == ST_FINISH);
  endproperty
  a_cmd_reject: assert property (p_cmd_reject) else $error("bad command code not rejected");

  property p_count_limit;
    @(posedge clk_sys) disable iff (rst)
    (q.state == ST_CHECK) && ((count_word == 16'h0000) || (count_word > 16'h0010))
      |=> (q.status_word == `STAT_ERR_COUNT) || (q.status_word == `STAT_ERR_CMD)
          || (q.status_word == `STAT_ERR_AREA);
  endproperty
  a_count_limit: assert property (p_count_limit) else $error("bad count accepted");

  property p_size_match;
    @(posedge clk_sys) disable iff (rst)
    (q.state == ST_CHECK) && (err_code == `STAT_PENDING)
      |-> (size_word == 16'h0004 + {count_word[13:0], 2'b00})
          && (size_word >= 16'h0008) && (size_word <= 16'h0044);
  endproperty
  a_size_match: assert property (p_size_match) else $error("size mismatch accepted");

  property p_number_range;
    @(posedge clk_sys) disable iff (rst)
    (q.state == ST_CHECK) && (err_code == `STAT_PENDING)
      |-> (start_word <= 16'h00ff) && (({1'b0, start_word} + {1'b0, count_word}) <= 17'h00100);
  endproperty
  a_number_range: assert property (p_number_range) else $error("range overflow accepted");

  property p_load_count;
    @(posedge clk_sys) disable iff (rst)
    (q.state == ST_FINISH) && !q.error |-> ({11'h000, q.loaded} == count_word);
  endproperty
  a_load_count: assert property (p_load_count) else $error("wrong number of values loaded");

  property p_value_pair;
    @(posedge clk_sys) disable iff (rst)
    (q.state == ST_LOAD) |=> q.wr_valid && (q.wr_value == $past(pair_value))
      && (q.wr_number == $past(q.number));
  endproperty
  a_value_pair: assert property (p_value_pair) else $error("value pair mangled");

  property p_reject_no_load;
    @(posedge clk_sys) disable iff (rst)
    (q.state == ST_CHECK) && (err_code != `STAT_PENDING)
      |=> !q.wr_valid ##1 !q.wr_valid && q.done && (q.status_word != `STAT_OK);
  endproperty
  a_reject_no_load: assert property (p_reject_no_load) else $error("rejected request loaded");

  property p_status_span;
    @(posedge clk_sys) disable iff (rst)
    stat_discrete |-> (stat_end == {16'h0000, stat_offset} + 32'h0000_000f);
  endproperty
  a_status_span: assert property (p_status_span) else $error("status bit span wrong");

  property p_status_zero_based;
    @(posedge clk_sys) disable iff (rst)
    stat_valid && !stat_discrete |-> (stat_end == {16'h0000, stat_offset});
  endproperty
  a_status_zero_based: assert property (p_status_zero_based) else $error("offset not zero based");

  property p_data_span;
    @(posedge clk_sys) disable iff (rst)
    data_discrete && (count_word <= 16'h0010)
      |-> (data_end == {16'h0000, data_offset} + 32'h0000_001f + {22'h0, count_word[4:0], 5'h00});
  endproperty
  a_data_span: assert property (p_data_span) else $error("discrete data span wrong");

  property p_area_codes;
    @(posedge clk_sys) disable iff (rst)
    ((stat_area == 16'h0046) || (stat_area == 16'h0048) |-> stat_discrete && stat_valid)
    and ((stat_area == 16'h000a) || (stat_area == 16'h000c) || (stat_area == 16'h0008)
         |-> !stat_discrete && stat_valid);
  endproperty
  a_area_codes: assert property (p_area_codes) else $error("area code misdecoded");

endmodule : parameter_load_request_parser

//--- src/request_checker.sv
// Validates the fields of a parameter-load request and yields a status code.
// Assumes its inputs are stable while the parser is in its check state.
`timescale 1ns/1ps
`include "parameter_load_defines.svh"

module request_checker
  import parameter_load_pkg::*;
(
  input  wire logic [15:0] cmd_code,
  input  wire logic [15:0] data_size,
  input  wire logic [15:0] start_number,
  input  wire logic [15:0] param_count,
  input  wire logic        status_valid,
  input  wire logic        data_valid,
  output logic [15:0]      err_code
);

  logic [17:0] need_size;
  logic [16:0] number_end;

  always_comb
  begin
    need_size  = `SPEC_BYTES + {param_count, 2'b00};
    number_end = {1'b0, start_number} + {1'b0, param_count};
    // Idle timeout and communication time words are not consulted.
    if (cmd_code != `CMD_PARAM_LOAD)
      err_code = `STAT_ERR_CMD;
    else if (!status_valid || !data_valid)
      err_code = `STAT_ERR_AREA;
    else if (param_count == 16'h0000 || param_count > `MAX_PARAMS)
      err_code = `STAT_ERR_COUNT;
    else if (start_number > `MAX_PARAM_NUMBER)
      err_code = `STAT_ERR_START;
    else if (number_end > `PARAM_NUMBER_END)
      err_code = `STAT_ERR_RANGE;
    else if (need_size != {2'b00, data_size})
      err_code = `STAT_ERR_SIZE;
    else
      err_code = `STAT_PENDING;
  end

endmodule : request_checker

//--- verification/request_source.sv
// Requester model: an APB master that builds command blocks and starts requests.
// Assumes the bench owns the clock and that the parser answers every access.
`timescale 1ns/1ps

module request_source
(
  input  wire logic        clk_sys,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic [31:0] rd_data;
  logic        rd_err;

  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h00000000;
  end

  // ==========================================================================
  // Bus transfer
  // Signals change just after a rising edge; the answer is taken at the rising edge
  // at which pready is seen high, and only then is the request released.
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
    begin
      @(posedge clk_sys);
    end
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~addr;
    pwdata  <= ~data;
  endtask : xfer

  // ==========================================================================
  // Command block
  // The block sits in word memory; the upper half carries junk the parser must drop.
  task automatic put_word(input int n, input logic [15:0] v);
    xfer(1'b1, 12'h100 + 12'(4 * (n - 1)), {16'hbeef, v});
  endtask : put_word

  function automatic logic [31:0] value_of(input int k);
    return 32'h3c5a0000 ^ (32'(k) * 32'h00070109);
  endfunction : value_of

  task automatic load_block(input logic [15:0] code, size, sarea, darea, start, count);
    put_word(1, 16'h0004);
    put_word(2, 16'h0000);
    put_word(3, sarea);
    put_word(4, 16'h00c2);
    put_word(5, 16'h0000);
    put_word(6, 16'h0000);
    put_word(7, code);
    put_word(8, size);
    put_word(9, darea);
    put_word(10, 16'h00cd);
    put_word(11, start);
    put_word(12, count);
    for (int k = 0; k < 16; k++)
    begin
      put_word(13 + 2 * k, 16'(value_of(k)));
      put_word(14 + 2 * k, 16'(value_of(k) >> 16));
    end
  endtask : load_block

endmodule : request_source

//--- verification/test_parameter_load_request_parser.sv
// Self-checking bench of the parameter-load request parser.
// Assumes the requester model drives the APB port and the design's constants header.
`timescale 1ns/1ps
`include "parameter_load_defines.svh"

module test_parameter_load_request_parser;
  typedef struct {logic [15:0] code, size, sarea, darea, start, count, stat;} case_type;

  logic        clk_sys;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        param_write_valid;
  logic [7:0]  param_write_number;
  logic [31:0] param_write_value;
  logic        request_busy;
  logic        request_done;
  int          num_errors;
  int          check_count;
  int          cycle_count;
  int          seen;
  int          busy_seen;
  logic [15:0] cur_start;

  case_type rows [11] = '{
    '{16'he501, 16'h0044, 16'h0008, 16'h0008, 16'h0001, 16'h0010, 16'h0001},
    '{16'he501, 16'h0008, 16'h000a, 16'h000c, 16'h0000, 16'h0001, 16'h0001},
    '{16'he501, 16'h0044, 16'h0046, 16'h0048, 16'h00f0, 16'h0010, 16'h0001},
    '{16'he501, 16'h0044, 16'h0048, 16'h0046, 16'h00f1, 16'h0010, 16'h0006},
    '{16'he501, 16'h0008, 16'h000c, 16'h000a, 16'h0100, 16'h0001, 16'h0005},
    '{16'he501, 16'h0004, 16'h0008, 16'h0008, 16'h0001, 16'h0000, 16'h0004},
    '{16'he501, 16'h0048, 16'h0008, 16'h0008, 16'h0001, 16'h0011, 16'h0004},
    '{16'he500, 16'h0008, 16'h0008, 16'h0008, 16'h0001, 16'h0001, 16'h0002},
    '{16'he501, 16'h000c, 16'h0008, 16'h0008, 16'h0001, 16'h0001, 16'h0007},
    '{16'he501, 16'h0008, 16'h0005, 16'h0008, 16'h0001, 16'h0001, 16'h0003},
    '{16'he501, 16'h0008, 16'h0008, 16'h0009, 16'h0001, 16'h0001, 16'h0003}};

  parameter_load_request_parser #(.PARAM_DEPTH(256)) DUT (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .param_write_valid(param_write_valid), .param_write_number(param_write_number),
    .param_write_value(param_write_value), .request_busy(request_busy),
    .request_done(request_done));

  request_source cpu (
    .clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // Checking
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string name);
    cpu.xfer(1'b0, a, 32'h00000000);
    check(name, cpu.rd_data, exp);
  endtask : rd

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  // Each load pulse must carry the next number and the matching value pair.
  always @(negedge clk_sys)
  begin
    if (request_busy === 1'b1)
      busy_seen++;
    if (param_write_valid === 1'b1)
    begin
      check("number", {24'h0, param_write_number}, 32'(cur_start) + 32'(seen));
      check("value", param_write_value, cpu.value_of(seen));
      seen++;
    end
  end

  always @(posedge clk_sys)
  begin
    cycle_count++;
    if (cycle_count == 20000)
    begin
      num_errors++;
      test_done;
    end
  end

  // ==========================================================================
  // Scenarios
  task automatic run_row(input case_type r, input logic poke);
    int          n;
    logic        disc;
    logic [31:0] exp_n;
    n     = 0;
    disc  = (r.darea == `AREA_DISC_IN || r.darea == `AREA_DISC_OUT);
    exp_n = (r.stat == `STAT_OK) ? {16'h0, r.count} : 32'h0;
    cpu.load_block(r.code, r.size, r.sarea, r.darea, r.start, r.count);
    cur_start = r.start;
    seen      = 0;
    busy_seen = 0;
    cpu.xfer(1'b1, `REG_CTRL, 32'h00000001);
    if (poke)
    begin
      cpu.xfer(1'b1, `REG_CTRL, 32'h00000001);
      check("restart refused", {31'h0, cpu.rd_err}, 32'h1);
      cpu.put_word(13, 16'h0000);
      check("block write refused", {31'h0, cpu.rd_err}, 32'h1);
    end
    @(negedge clk_sys);
    while (request_done !== 1'b1 && n < 200)
    begin
      n++;
      @(negedge clk_sys);
    end
    check("done", {31'h0, request_done}, 32'h1);
    check("busy cycles", 32'(busy_seen), exp_n + 32'h2);
    check("loads", 32'(seen), exp_n);
    rd(`REG_STATUS_WORD, {16'h0, r.stat}, "status word");
    rd(`REG_STATUS, {29'h0, r.stat != `STAT_OK, 2'b10}, "status");
    if (r.stat == `STAT_OK)
    begin
      rd(`REG_STATUS_END, (r.sarea == 16'h0046 || r.sarea == 16'h0048) ? 32'hd1 : 32'hc2,
         "status end");
      rd(`REG_DATA_END, 32'hcc + (disc ? 32'h20 : 32'h2) * (32'(r.count) + 32'h1),
         "data end");
      rd(`REG_LOAD_COUNT, exp_n, "load count");
    end
  endtask : run_row

  initial
  begin
    rst = 1'b1;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      run_row(rows[i], i == 0);
      $display("test %0d done", i);
    end
    cpu.xfer(1'b0, 12'h0f0, 32'h00000000);
    check("unmapped error", {31'h0, cpu.rd_err}, 32'h1);
    check("unmapped data", cpu.rd_data, 32'h0);
    cpu.xfer(1'b1, `REG_PARAM_INDEX, 32'h000000ff);
    rd(`REG_PARAM_INDEX, 32'h000000ff, "parameter index");
    rd(`REG_PARAM_VALUE, cpu.value_of(15), "parameter 255");
    rd(12'h100, 32'h00000004, "block word 1");
    $display("test readback done");
    cpu.load_block(16'he501, 16'h0044, 16'h0008, 16'h0008, 16'h0001, 16'h0010);
    cpu.xfer(1'b1, `REG_CTRL, 32'h00000001);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check("busy in reset", {31'h0, request_busy}, 32'h0);
    check("load in reset", {31'h0, param_write_valid}, 32'h0);
    rst <= 1'b0;
    rd(`REG_STATUS, 32'h0, "status after reset");
    rd(`REG_STATUS_WORD, {16'h0, `STAT_PENDING}, "word after reset");
    $display("test reset done");
    test_done;
  end

endmodule : test_parameter_load_request_parser
